/* File: design/phc_regs.svh */
`ifndef PHC_REGS_SVH
`define PHC_REGS_SVH

// Controller register offsets on the plain command port
`define PHC_OFS_CMD      4'h0
`define PHC_OFS_STATUS   4'h4
`define PHC_OFS_RESULT   4'h8

// Command word fields
`define PHC_CMD_DATA_LSB 0
`define PHC_CMD_A0_BIT   8
`define PHC_CMD_TGT_BIT  9
`define PHC_CMD_OP_LSB   10

// Operation codes
`define PHC_OP_WRITE     3'h0
`define PHC_OP_READ      3'h1
`define PHC_OP_STATUS    3'h2
`define PHC_OP_ACK       3'h3
`define PHC_OP_NEST_EXIT 3'h4

// Device command words
`define PHC_WORD_EOI_NS  8'h20
`define PHC_WORD_RD_PEND 8'h0b
`define PHC_WORD_RD_SERV 8'h0a
`define PHC_INIT_WORD_ONE_BIT     4
`define PHC_OP_WORD_THREE_BIT     3
`define PHC_LEVEL_TRIGGER_SEL_BIT     3
`define PHC_POLL_BIT     2
`define PHC_RR_BIT       1
`define PHC_RIS_BIT      0

// Timing
`define PHC_CLK_MHZ      50
`define PHC_STROBE_NS    100
`define PHC_RECOV_NS     60
`define PHC_STROBE_CYC   ((`PHC_STROBE_NS * `PHC_CLK_MHZ + 999) / 1000)
`define PHC_RECOV_CYC    ((`PHC_RECOV_NS * `PHC_CLK_MHZ + 999) / 1000)
`define PHC_ACK_PULSES   3

`endif

/* File: design/phc_pkg.sv */
package phc_pkg;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_setup = 2'b01,
        st_pulse = 2'b11,
        st_recov = 2'b10
    } phc_state_type;

    typedef enum logic [1:0] {
        cyc_none  = 2'h0,
        cyc_write = 2'h1,
        cyc_read  = 2'h2,
        cyc_ack   = 2'h3
    } phc_kind_type;

    typedef struct packed {
        phc_kind_type kind;
        logic         tgt;
        logic         a0;
        logic [7:0]   data;
    } phc_cyc_type;

    typedef struct packed {
        phc_state_type st;
        logic [7:0]    cnt;
        logic [1:0]    step;
        logic [2:0]    op;
        logic [7:0]    cdata;
        logic          ca0;
        logic          ctgt;
        logic [7:0]    rdata;
        logic [2:0]    cas;
        logic          sel_valid;
        logic          sel_is;
        logic          level_trigger_sel;
        logic          buf_seen;
        logic          master_eoi;
        logic [31:0]   bus_rdata;
    } phc_state_reg_type;

endpackage

/* File: design/phc_host.sv */
// Decided for this implementation: the address-and-strobe port and the address map.
`include "phc_regs.svh"

// Contract
// - Host writes op word three before status reads; master reads skip it while the tracked selection already matches.
// - Level mode: remove request before end-of-service.
// - Request held past first acknowledge, else level seven.
// - Nested exit: slave end, read, then maybe master.
// - Host initializes and ends service on each controller.
module phc_host #(
    parameter int ACK_PULSES = `PHC_ACK_PULSES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    output logic      [1:0]  dev_cs_n,
    output logic             dev_wr_n,
    output logic             dev_rd_n,
    output logic             dev_ack_n,
    output logic             dev_a0,
    output logic      [7:0]  dev_d_out,
    output logic             dev_d_oe_n,
    input  wire logic [7:0]  dev_d_in,
    input  wire logic        dev_int,
    input  wire logic        dev_buf_en_n,
    input  wire logic [2:0]  dev_cas,
    input  wire logic        request_active
);

    localparam logic [7:0] STROBE_CYC = 8'(`PHC_STROBE_CYC);
    localparam logic [7:0] RECOV_CYC  = 8'(`PHC_RECOV_CYC);

    phc_pkg::phc_state_reg_type r_reg;
    phc_pkg::phc_state_reg_type r_next;
    phc_pkg::phc_cyc_type       cyc;

    function automatic logic is_eoi(input logic a0, input logic [7:0] d);
        return !a0 && d[5] && (d[4:3] == 2'b00);
    endfunction

    function automatic logic last_step(input logic [2:0] op, input logic [1:0] step);
        case (op)
            `PHC_OP_STATUS:    last_step = (step == 2'h1);
            `PHC_OP_ACK:       last_step = (32'(step) >= ACK_PULSES - 1);
            `PHC_OP_NEST_EXIT: last_step = (step == 2'h3);
            default:           last_step = 1'b1;
        endcase
    endfunction

    function automatic phc_pkg::phc_cyc_type cyc_of(input phc_pkg::phc_state_reg_type s);
        phc_pkg::phc_cyc_type c;
        c = '{kind: phc_pkg::cyc_none, tgt: s.ctgt, a0: s.ca0, data: s.cdata};
        case (s.op)
            `PHC_OP_WRITE: begin
                c.kind = phc_pkg::cyc_write;
            end
            `PHC_OP_READ: begin
                c.kind = phc_pkg::cyc_read;
            end
            `PHC_OP_STATUS: begin
                c.a0 = 1'b0;
                if (s.step == 2'h0) begin
                    c.data = s.cdata[0] ? `PHC_WORD_RD_SERV : `PHC_WORD_RD_PEND;
                    if (!(s.ctgt == 1'b0 && s.sel_valid && s.sel_is == s.cdata[0])) begin
                        c.kind = phc_pkg::cyc_write;
                    end
                end else begin
                    c.kind = phc_pkg::cyc_read;
                end
            end
            `PHC_OP_ACK: begin
                c.kind = phc_pkg::cyc_ack;
            end
            default: begin
                // slave end, slave read, then master only if the slave in-service read is zero
                c.a0 = 1'b0;
                c.tgt = 1'b1;
                if (s.step == 2'h0) begin
                    c.kind = phc_pkg::cyc_write;
                    c.data = `PHC_WORD_EOI_NS;
                end else if (s.step == 2'h1) begin
                    c.kind = phc_pkg::cyc_write;
                    c.data = `PHC_WORD_RD_SERV;
                end else if (s.step == 2'h2) begin
                    c.kind = phc_pkg::cyc_read;
                end else begin
                    c.tgt = 1'b0;
                    c.data = `PHC_WORD_EOI_NS;
                    if (s.rdata == 8'h00) begin
                        c.kind = phc_pkg::cyc_write;
                    end
                end
            end
        endcase
        return c;
    endfunction

    assign cyc = cyc_of(r_reg);

    always_comb begin
        r_next = r_reg;
        r_next.bus_rdata = 32'h0000_0000;
        if (bus_rd) begin
            if (bus_addr == `PHC_OFS_STATUS) begin
                r_next.bus_rdata = {25'h0, r_reg.master_eoi, r_reg.buf_seen, r_reg.level_trigger_sel,
                                    r_reg.sel_valid, r_reg.sel_is, dev_int,
                                    (r_reg.st != phc_pkg::st_idle)};
            end else if (bus_addr == `PHC_OFS_RESULT) begin
                r_next.bus_rdata = {21'h0, r_reg.cas, r_reg.rdata};
            end
        end
        case (r_reg.st)
            phc_pkg::st_idle: begin
                if (bus_wr && bus_addr == `PHC_OFS_CMD) begin
                    r_next.cdata = bus_wdata[`PHC_CMD_DATA_LSB +: 8];
                    r_next.ca0 = bus_wdata[`PHC_CMD_A0_BIT];
                    r_next.ctgt = bus_wdata[`PHC_CMD_TGT_BIT];
                    r_next.op = bus_wdata[`PHC_CMD_OP_LSB +: 3];
                    r_next.step = 2'h0;
                    r_next.st = phc_pkg::st_setup;
                    if (bus_wdata[`PHC_CMD_OP_LSB +: 3] == `PHC_OP_NEST_EXIT) begin
                        r_next.master_eoi = 1'b0;
                    end
                end
            end
            phc_pkg::st_setup: begin
                if (cyc.kind == phc_pkg::cyc_none) begin
                    if (last_step(r_reg.op, r_reg.step)) begin
                        r_next.st = phc_pkg::st_idle;
                    end else begin
                        r_next.step = r_reg.step + 2'h1;
                    end
                end else if (!(cyc.kind == phc_pkg::cyc_write && is_eoi(cyc.a0, cyc.data)
                               && r_reg.level_trigger_sel && request_active)) begin
                    r_next.st = phc_pkg::st_pulse;
                    r_next.cnt = STROBE_CYC - 8'h01;
                end
            end
            phc_pkg::st_pulse: begin
                if (!dev_buf_en_n) begin
                    r_next.buf_seen = 1'b1;
                end
                if (r_reg.cnt == 8'h00) begin
                    if (cyc.kind == phc_pkg::cyc_read || cyc.kind == phc_pkg::cyc_ack) begin
                        r_next.rdata = dev_d_in;
                    end
                    if (cyc.kind == phc_pkg::cyc_ack && r_reg.step == 2'h1) begin
                        r_next.cas = dev_cas;
                    end
                    r_next.st = phc_pkg::st_recov;
                    r_next.cnt = RECOV_CYC - 8'h01;
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end
            end
            default: begin
                if (r_reg.cnt == 8'h00) begin
                    if (cyc.kind == phc_pkg::cyc_write && !cyc.a0 && !cyc.tgt) begin
                        if (cyc.data[`PHC_INIT_WORD_ONE_BIT]) begin
                            r_next.level_trigger_sel = cyc.data[`PHC_LEVEL_TRIGGER_SEL_BIT];
                            r_next.sel_valid = 1'b1;
                            r_next.sel_is = 1'b0;
                        end else if (cyc.data[4:3] == 2'b01) begin
                            if (cyc.data[`PHC_POLL_BIT]) begin
                                r_next.sel_valid = 1'b0;
                            end else if (cyc.data[`PHC_RR_BIT]) begin
                                r_next.sel_valid = 1'b1;
                                r_next.sel_is = !cyc.data[`PHC_RIS_BIT];
                            end
                        end
                        if (r_reg.op == `PHC_OP_NEST_EXIT) begin
                            r_next.master_eoi = 1'b1;
                        end
                    end
                    if (last_step(r_reg.op, r_reg.step)) begin
                        r_next.st = phc_pkg::st_idle;
                    end else begin
                        r_next.step = r_reg.step + 2'h1;
                        r_next.st = phc_pkg::st_setup;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{st: phc_pkg::st_idle, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    logic bus_cyc;
    assign bus_cyc    = (r_reg.st != phc_pkg::st_idle)
                        && (cyc.kind == phc_pkg::cyc_write || cyc.kind == phc_pkg::cyc_read);
    assign bus_rdata  = r_reg.bus_rdata;
    assign dev_cs_n   = bus_cyc ? (cyc.tgt ? 2'b01 : 2'b10) : 2'b11;
    assign dev_wr_n   = !(r_reg.st == phc_pkg::st_pulse && cyc.kind == phc_pkg::cyc_write);
    assign dev_rd_n   = !(r_reg.st == phc_pkg::st_pulse && cyc.kind == phc_pkg::cyc_read);
    assign dev_ack_n  = !(r_reg.st == phc_pkg::st_pulse && cyc.kind == phc_pkg::cyc_ack);
    assign dev_a0     = bus_cyc ? cyc.a0 : 1'b0;
    assign dev_d_out  = bus_cyc ? cyc.data : 8'h00;
    assign dev_d_oe_n = !(bus_cyc && cyc.kind == phc_pkg::cyc_write);

    a_strobes_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        !(!dev_wr_n && !dev_rd_n) && !(!dev_ack_n && !dev_cs_n[0]))
        else $error("Read, write and acknowledge strobes overlap");

    a_status_selected: assert property (@(posedge mclk) disable iff (!rst_n)
        ($fell(dev_rd_n) && r_reg.op == `PHC_OP_STATUS && !cyc.tgt)
        |-> (r_reg.sel_valid && r_reg.sel_is == r_reg.cdata[0]))
        else $error("Status read without matching selection");

    a_init_default: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(dev_wr_n) && !dev_cs_n[0] && !dev_a0 && dev_d_out[`PHC_INIT_WORD_ONE_BIT])
        ##[1:8] (r_reg.st != phc_pkg::st_recov)
        |-> (r_reg.sel_valid && !r_reg.sel_is))
        else $error("Selection not pending after init word one");

    a_level_eoi_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        ($fell(dev_wr_n) && r_reg.level_trigger_sel && is_eoi(dev_a0, dev_d_out))
        |-> !$past(request_active))
        else $error("End-of-service sent with request still high");

    a_ack_width: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(dev_ack_n) |-> (!dev_ack_n)[*5] ##1 dev_ack_n)
        else $error("Acknowledge strobe width wrong");

    a_nest_master_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        (!dev_wr_n && r_reg.op == `PHC_OP_NEST_EXIT && r_reg.step == 2'h3)
        |-> (r_reg.rdata == 8'h00 && !dev_cs_n[0] && dev_cs_n[1]))
        else $error("Master end sent while slave still in service");

    a_nest_slave_first: assert property (@(posedge mclk) disable iff (!rst_n)
        ((r_reg.st == phc_pkg::st_pulse) && r_reg.op == `PHC_OP_NEST_EXIT
         && r_reg.step != 2'h3) |-> (dev_cs_n == 2'b01))
        else $error("Nested exit touched master before slave done");

endmodule

/* File: test/phc_dev_model.sv */
module phc_dev_model #(
    parameter bit MASTER = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       cs_n,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic       ack_n,
    input  wire logic       a0,
    input  wire logic [7:0] d_in,
    input  wire logic [7:0] req,
    output logic      [7:0] d_out,
    output logic            drv,
    output logic            int_o,
    output logic            buf_en_n,
    output logic      [2:0] cas
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pend_reg = 8'h00, serv_reg = 8'h00, mask_reg = 8'h00;
    logic [7:0] slv_reg = 8'h00, req_q = 8'h00, live;
    logic [1:0] left = 2'h0, acnt = 2'h0;
    logic [2:0] lvl = 3'h0;
    logic       level_trigger_sel = 1'b0, sel_pend = 1'b1, poll = 1'b0, bufm = 1'b0;
    logic       wr_q = 1'b1, rd_q = 1'b1, ack_q = 1'b1;
    function automatic logic [2:0] hi(input logic [7:0] v);
        hi = 3'h7;
        for (int i = 7; i >= 0; i--) if (v[i]) hi = i[2:0];
    endfunction
    assign live = pend_reg & ~mask_reg;
    assign d_out = !ack_n ? (acnt == 2'h0 ? 8'hcd : {acnt, 3'h0, lvl}) :
        poll ? {int_o, 4'h0, hi(live)} : a0 ? mask_reg : sel_pend ? pend_reg : serv_reg;
    assign drv = (!cs_n && !rd_n) || (MASTER && !ack_n);
    assign int_o = |live;
    assign buf_en_n = !(drv && bufm);
    assign cas = (MASTER && acnt != 2'h0 && slv_reg[lvl]) ? lvl : 3'h0;
    always @(posedge mclk) begin
        wr_q <= wr_n;
        rd_q <= rd_n;
        ack_q <= ack_n;
        req_q <= req;
        pend_reg <= level_trigger_sel ? req : (pend_reg | (req & ~req_q)) & req;
        if (!wr_q && wr_n && !cs_n) begin
            if (!a0 && d_in[4]) begin
                level_trigger_sel <= d_in[3];
                sel_pend <= 1'b1;
                left <= 2'h3;
            end else if (a0 && left != 2'h0) begin
                left <= left - 2'h1;
                if (left == 2'h2) slv_reg <= d_in;
                if (left == 2'h1) bufm <= d_in[3];
            end else if (a0) begin
                mask_reg <= d_in;
            end else if (d_in[3]) begin
                poll <= d_in[2];
                if (d_in[1]) sel_pend <= d_in[0];
            end else if (d_in[5]) begin
                serv_reg[hi(serv_reg)] <= 1'b0;
            end
        end
        if (!rd_q && rd_n && !cs_n) poll <= 1'b0;
        if (MASTER && ack_q && !ack_n && acnt == 2'h0) begin
            lvl <= hi(live);
            if (live != 8'h00) begin
                serv_reg[hi(live)] <= 1'b1;
                pend_reg[hi(live)] <= 1'b0;
            end
        end
        if (!ack_q && ack_n) acnt <= (acnt == 2'h2) ? 2'h0 : acnt + 2'h1;
    end
endmodule

/* File: test/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n, bus_wr, bus_rd, m_drv, s_drv, m_int, m_buf, s_buf;
    logic        dev_wr_n, dev_rd_n, dev_ack_n, dev_a0, dev_d_oe_n;
    logic [1:0]  dev_cs_n;
    logic [2:0]  dev_cas;
    logic [3:0]  bus_addr;
    logic [7:0]  dev_d_out, dev_d_in, m_d, s_d, req;
    logic [31:0] bus_wdata, bus_rdata, rv;
    int          bad_count = 0, cmp_count = 0;
    // Released data bus toggles on every clock edge
    assign dev_d_in = m_drv ? m_d : (s_drv ? s_d : {8{mclk}} ^ 8'h5a);
    phc_host #(.ACK_PULSES(3)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .dev_cs_n(dev_cs_n),
        .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .dev_ack_n(dev_ack_n), .dev_a0(dev_a0),
        .dev_d_out(dev_d_out), .dev_d_oe_n(dev_d_oe_n), .dev_d_in(dev_d_in),
        .dev_int(m_int), .dev_buf_en_n(m_buf & s_buf), .dev_cas(dev_cas),
        .request_active(|req));
    phc_dev_model #(.MASTER(1'b1)) i_master (
        .mclk(mclk), .cs_n(dev_cs_n[0]), .wr_n(dev_wr_n), .rd_n(dev_rd_n), .ack_n(dev_ack_n),
        .a0(dev_a0), .d_in(dev_d_oe_n ? ~dev_d_out : dev_d_out), .req(req), .d_out(m_d),
        .drv(m_drv), .int_o(m_int),
        .buf_en_n(m_buf), .cas(dev_cas));
    phc_dev_model #(.MASTER(1'b0)) i_slave (
        .mclk(mclk), .cs_n(dev_cs_n[1]), .wr_n(dev_wr_n), .rd_n(dev_rd_n), .ack_n(1'b1),
        .a0(dev_a0), .d_in(dev_d_oe_n ? ~dev_d_out : dev_d_out), .req(8'h00), .d_out(s_d),
        .drv(s_drv), .int_o(),
        .buf_en_n(s_buf), .cas());
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] m);
        cmp_count++;
        if ((rv & m) !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", w, e, rv & m);
        end
    endtask
    task automatic bw(input logic [3:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic br(input logic [3:0] a);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 rv = bus_rdata;
        @(posedge mclk);
    endtask
    task automatic idle();
        for (int i = 0; i < 60; i++) begin
            br(4'h4);
            if (rv[0] === 1'b0) return;
        end
        bad_count++;
        $display("[ERR] busy expected 0 seen 1");
        test_done();
    endtask
    task automatic cmd(input logic [2:0] op, input logic t, input logic a, input logic [7:0] d);
        bw(4'h0, {19'h0, op, t, a, d});
        idle();
    endtask
    task automatic run(input logic [2:0] op, input logic t, input logic a, input logic [7:0] d);
        cmd(op, t, a, d);
        br(4'h8);
    endtask
    task automatic init(input logic [7:0] w1);
        cmd(3'h0, 1'b0, 1'b0, w1);
        cmd(3'h0, 1'b0, 1'b1, 8'h20);
        cmd(3'h0, 1'b0, 1'b1, 8'h04);
        cmd(3'h0, 1'b0, 1'b1, 8'h0d);
        br(4'h4);
    endtask
    initial begin
        rst_n = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 32'h0;
        req = 8'h00;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        br(4'h4);
        chk("status_rst", 32'h0, 32'hffff_ffff);
        bw(4'hc, 32'hffff_ffff);
        br(4'hc);
        chk("unmapped", 32'h0, 32'hffff_ffff);
        init(8'h11);
        chk("status_init", 32'h08, 32'hffff_fffd);
        run(3'h1, 1'b0, 1'b1, 8'h00);
        chk("mask_rst", 32'h00, 32'hff);
        cmd(3'h0, 1'b0, 1'b1, 8'h80);
        run(3'h1, 1'b0, 1'b1, 8'h00);
        chk("mask", 32'h80, 32'hff);
        br(4'h4);
        chk("buf_seen", 32'h20, 32'h20);
        $display("test init done");
        req <= 8'h01;
        repeat (3) @(posedge mclk);
        br(4'h4);
        chk("int_seen", 32'h02, 32'h02);
        run(3'h2, 1'b0, 1'b0, 8'h00);
        chk("pend_edge", 32'h01, 32'hff);
        run(3'h3, 1'b0, 1'b0, 8'h00);
        chk("ack_plain", 32'h080, 32'h7ff);
        run(3'h2, 1'b0, 1'b0, 8'h00);
        chk("pend_held", 32'h00, 32'hff);
        run(3'h2, 1'b0, 1'b0, 8'h01);
        chk("serv_set", 32'h01, 32'hff);
        cmd(3'h0, 1'b0, 1'b0, 8'h20);
        run(3'h2, 1'b0, 1'b0, 8'h01);
        chk("serv_eoi", 32'h00, 32'hff);
        $display("test edge done");
        req <= 8'h05;
        repeat (3) @(posedge mclk);
        run(3'h3, 1'b0, 1'b0, 8'h00);
        chk("ack_slave", 32'h282, 32'h7ff);
        req <= 8'h0d;
        repeat (2) @(posedge mclk);
        req <= 8'h05;
        repeat (3) @(posedge mclk);
        run(3'h3, 1'b0, 1'b0, 8'h00);
        chk("ack_dflt", 32'h087, 32'h7ff);
        run(3'h2, 1'b0, 1'b0, 8'h01);
        chk("serv_dflt", 32'h04, 32'hff);
        $display("test cascade done");
        req <= 8'h00;
        init(8'h19);
        chk("level_trigger_sel", 32'h18, 32'h1d);
        req <= 8'h02;
        repeat (3) @(posedge mclk);
        run(3'h2, 1'b0, 1'b0, 8'h00);
        chk("pend_level", 32'h02, 32'hff);
        bw(4'h0, {19'h0, 3'h0, 1'b0, 1'b0, 8'h20});
        repeat (30) @(posedge mclk);
        br(4'h4);
        chk("eoi_held", 32'h01, 32'h01);
        req <= 8'h00;
        idle();
        $display("test level done");
        run(3'h4, 1'b1, 1'b0, 8'h20);
        br(4'h4);
        chk("nest_exit", 32'h40, 32'h40);
        cmd(3'h0, 1'b0, 1'b0, 8'h0c);
        br(4'h4);
        chk("poll_cache", 32'h00, 32'h08);
        req <= 8'h02;
        repeat (3) @(posedge mclk);
        run(3'h1, 1'b0, 1'b0, 8'h00);
        chk("poll_read", 32'h81, 32'hff);
        $display("test poll done");
        test_done();
    end
endmodule
